/* File: rtl/cccr_params.svh */
// constants of the core common control register bank
`ifndef CCCR_PARAMS_SVH
`define CCCR_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CCCR_ADDR_WIDTH         20
`define CCCR_OFS_SELECT_MODE    20'h3_0a05
`define CCCR_OFS_RESET_CTRL     20'h3_0a06
`define CCCR_OFS_TX_STROBE      20'h3_0a07
`define CCCR_OFS_ALARM_SUMMARY  20'h3_0a08
`define CCCR_OFS_SECTION_TALLY  20'h3_0a09
`define CCCR_OFS_CELL_TALLY     20'h3_0a0a

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCCR_SEL_LSB            0
`define CCCR_SEL_MSB            2
`define CCCR_PAIR_LSB           3
`define CCCR_PAIR_MSB           6
`define CCCR_ALL_BIT            7
`define CCCR_PHASE_LSB          5
`define CCCR_PHASE_MSB          6
`define CCCR_SOFT_RESET_BIT     7
`define CCCR_TX_DONE_BIT        7

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define CCCR_RESET_SELECT_MODE  8'h00
`define CCCR_RESET_RESET_CTRL   8'h00
`define CCCR_RESET_TX_STROBE    8'h00
`define CCCR_RESET_TALLY        8'h00
`define CCCR_TALLY_MAX          8'hff
`define CCCR_CHANNELS           8
`define CCCR_ALARMS_PER_CH      8
`define CCCR_PHASE_STAGES       3

`endif

/* File: rtl/cccr_pkg.sv */
// types of the core common control register bank
package cccr_pkg;

    // ----------------------------------------------------------------
    // register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [19:0] address;
        logic [7:0]  writeData;
        logic        writeStrobe;
        logic        readStrobe;
    } cccr_request_type;

    // ----------------------------------------------------------------
    // effective cell mode grouping
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       allLinks;
        logic [3:0] pairs;
    } cccr_cell_mode_type;

    typedef logic [2:0] cccr_channel_type;
    typedef logic [1:0] cccr_phase_type;

endpackage : cccr_pkg

/* File: rtl/cccr_reset_delay.sv */
// soft reset delay by a selectable phase
`timescale 1ns/1ps
`include "cccr_params.svh"

module cccr_reset_delay
(
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    // request and phase
    input  wire logic                     request,
    input  wire cccr_pkg::cccr_phase_type phase,
    // delayed reset
    output logic                          applied
);

    // ----------------------------------------------------------------
    // delay line
    // ----------------------------------------------------------------
    logic [`CCCR_PHASE_STAGES-1:0] stage_reg;
    logic                          applied_next;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            stage_reg <= '0;
        else
            stage_reg <= {stage_reg[`CCCR_PHASE_STAGES-2:0], request};
    end

    // phase 00 applies one cycle after the request, 11 four cycles after
    always_comb
    begin
        case (phase)
            2'h0:    applied_next = request;
            2'h1:    applied_next = stage_reg[0];
            2'h2:    applied_next = stage_reg[1];
            2'h3:    applied_next = stage_reg[2];
            default: applied_next = 1'b0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            applied <= 1'b0;
        else
            applied <= applied_next;
    end

endmodule : cccr_reset_delay

/* File: rtl/cccr_top.sv */
// core common control register bank
`timescale 1ns/1ps
`include "cccr_params.svh"

module cccr_top
(
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    // register port
    input  wire cccr_pkg::cccr_request_type   request,
    output logic [7:0]                        readData,
    // channel events, index 0 is AA up to 7 is BD
    input  wire logic [7:0]                   sectionParityError,
    input  wire logic [7:0]                   cellParityError,
    input  wire logic [63:0]                  channelAlarms,
    // core controls
    output cccr_pkg::cccr_cell_mode_type      cellMode,
    output logic                              coreSoftReset,
    output logic                              serdesSoftReset,
    output logic                              txConfigDone,
    output logic                              alarmIndication
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic writeSelect;
    logic writeReset;
    logic writeStrobeReg;
    logic readSection;
    logic readCell;

    assign writeSelect    = request.writeStrobe
                            && (request.address == `CCCR_OFS_SELECT_MODE);
    assign writeReset     = request.writeStrobe
                            && (request.address == `CCCR_OFS_RESET_CTRL);
    assign writeStrobeReg = request.writeStrobe
                            && (request.address == `CCCR_OFS_TX_STROBE);
    assign readSection    = request.readStrobe
                            && (request.address == `CCCR_OFS_SECTION_TALLY);
    assign readCell       = request.readStrobe
                            && (request.address == `CCCR_OFS_CELL_TALLY);

    // ----------------------------------------------------------------
    // software registers, kept through the soft reset
    // ----------------------------------------------------------------
    logic [7:0] selectMode_reg;
    logic [7:0] resetCtrl_reg;
    logic [7:0] txStrobe_reg;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            selectMode_reg <= `CCCR_RESET_SELECT_MODE;
        else if (writeSelect)
            selectMode_reg <= request.writeData;
    end

    // reserved bits are stored as zero
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            resetCtrl_reg <= `CCCR_RESET_RESET_CTRL;
        else if (writeReset)
            resetCtrl_reg <= request.writeData
                             & 8'he0;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            txStrobe_reg <= `CCCR_RESET_TX_STROBE;
        else if (writeStrobeReg)
            txStrobe_reg <= request.writeData
                            & 8'h80;
    end

    // ----------------------------------------------------------------
    // channel select and cell mode
    // ----------------------------------------------------------------
    cccr_pkg::cccr_channel_type   tallyChannelSelect;
    logic                         allCellEnable;
    logic                         pairALowCellEnable;
    logic                         pairAHighCellEnable;
    logic                         pairBLowCellEnable;
    logic                         pairBHighCellEnable;
    logic [3:0]                   pairCellEnable;
    cccr_pkg::cccr_cell_mode_type cellMode_next;

    assign tallyChannelSelect  = selectMode_reg[`CCCR_SEL_MSB:`CCCR_SEL_LSB];
    assign allCellEnable       = selectMode_reg[`CCCR_ALL_BIT];
    assign pairALowCellEnable  = selectMode_reg[`CCCR_PAIR_LSB];
    assign pairAHighCellEnable = selectMode_reg[`CCCR_PAIR_LSB + 1];
    assign pairBLowCellEnable  = selectMode_reg[`CCCR_PAIR_LSB + 2];
    assign pairBHighCellEnable = selectMode_reg[`CCCR_PAIR_MSB];
    assign pairCellEnable      = {pairBHighCellEnable, pairBLowCellEnable,
                                  pairAHighCellEnable, pairALowCellEnable};

    // pair enables are dropped while all links form one group
    always_comb
    begin
        cellMode_next.allLinks = allCellEnable;
        cellMode_next.pairs    = pairCellEnable;
        if (allCellEnable)
            cellMode_next.pairs = 4'h0;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            cellMode <= '0;
        else
            cellMode <= cellMode_next;
    end

    // ----------------------------------------------------------------
    // soft reset with phase delay
    // ----------------------------------------------------------------
    logic                     softResetRequest;
    cccr_pkg::cccr_phase_type resetPhase;
    logic                     softApplied;

    assign softResetRequest = resetCtrl_reg[`CCCR_SOFT_RESET_BIT];
    assign resetPhase       = resetCtrl_reg[`CCCR_PHASE_MSB:`CCCR_PHASE_LSB];

    cccr_reset_delay u_cccr_reset_delay
    (
        .clock   (clock),
        .reset_n (reset_n),
        .request (softResetRequest),
        .phase   (resetPhase),
        .applied (softApplied)
    );

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            coreSoftReset <= 1'b0;
        else
            coreSoftReset <= softApplied;
    end

    // serializer blocks never see the soft reset
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            serdesSoftReset <= 1'b0;
        else
            serdesSoftReset <= 1'b0;
    end

    // ----------------------------------------------------------------
    // transmit done edge detect
    // ----------------------------------------------------------------
    logic txDonePrev_reg;
    logic txDoneBit;

    assign txDoneBit = txStrobe_reg[`CCCR_TX_DONE_BIT];

    // core flop, set to one by the soft reset so a held one gives no edge
    always_ff @(posedge clock)
    begin
        if (!reset_n || coreSoftReset)
            txDonePrev_reg <= 1'b1;
        else
            txDonePrev_reg <= txDoneBit;
    end

    // the host writes 0 then 1 to make this edge
    always_ff @(posedge clock)
    begin
        if (!reset_n || coreSoftReset)
            txConfigDone <= 1'b0;
        else
            txConfigDone <= txDoneBit && !txDonePrev_reg;
    end

    // ----------------------------------------------------------------
    // alarm summary
    // ----------------------------------------------------------------
    logic [7:0] alarmSummary_next;
    logic [7:0] channelAlarmSummaryBit;

    // summary bits follow the alarm levels, reading does not clear them
    genvar bitIndex;
    generate
        for (bitIndex = 0; bitIndex < `CCCR_CHANNELS; bitIndex = bitIndex + 1)
        begin : summaryBits
            assign alarmSummary_next[bitIndex] =
                |channelAlarms[(7 - bitIndex) * 8 +: 8];
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            channelAlarmSummaryBit <= 8'h00;
        else
            channelAlarmSummaryBit <= alarmSummary_next;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            alarmIndication <= 1'b0;
        else
            alarmIndication <= |alarmSummary_next;
    end

    // ----------------------------------------------------------------
    // parity error tallies
    // ----------------------------------------------------------------
    logic [7:0] sectionParityErrorTally_reg;
    logic [7:0] cellParityErrorTally_reg;
    logic [7:0] sectionParityErrorTally_next;
    logic [7:0] cellParityErrorTally_next;
    logic       sectionHit;
    logic       cellHit;

    assign sectionHit = sectionParityError[tallyChannelSelect];
    assign cellHit    = cellParityError[tallyChannelSelect];

    // a read clears first, so an error in the read cycle leaves one
    always_comb
    begin
        sectionParityErrorTally_next = sectionParityErrorTally_reg;
        if (readSection)
            sectionParityErrorTally_next = {7'h00, sectionHit};
        else if (sectionHit && sectionParityErrorTally_reg != `CCCR_TALLY_MAX)
            sectionParityErrorTally_next = sectionParityErrorTally_reg + 8'h01;
    end

    always_comb
    begin
        cellParityErrorTally_next = cellParityErrorTally_reg;
        if (readCell)
            cellParityErrorTally_next = {7'h00, cellHit};
        else if (cellHit && cellParityErrorTally_reg != `CCCR_TALLY_MAX)
            cellParityErrorTally_next = cellParityErrorTally_reg + 8'h01;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            sectionParityErrorTally_reg <= `CCCR_RESET_TALLY;
        else
            sectionParityErrorTally_reg <= sectionParityErrorTally_next;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            cellParityErrorTally_reg <= `CCCR_RESET_TALLY;
        else
            cellParityErrorTally_reg <= cellParityErrorTally_next;
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] readData_next;

    // unmapped offsets read zero
    always_comb
    begin
        case (request.address)
            `CCCR_OFS_SELECT_MODE:   readData_next = selectMode_reg;
            `CCCR_OFS_RESET_CTRL:    readData_next = resetCtrl_reg;
            `CCCR_OFS_TX_STROBE:     readData_next = txStrobe_reg;
            `CCCR_OFS_ALARM_SUMMARY: readData_next = channelAlarmSummaryBit;
            `CCCR_OFS_SECTION_TALLY: readData_next = sectionParityErrorTally_reg;
            `CCCR_OFS_CELL_TALLY:    readData_next = cellParityErrorTally_reg;
            default:                 readData_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            readData <= 8'h00;
        else if (request.readStrobe)
            readData <= readData_next;
        else
            readData <= 8'h00;
    end

endmodule : cccr_top

/* File: verif/cccr_props.sv */
// port assertions for the core common control register bank
`timescale 1ns/1ps
`include "cccr_params.svh"

module cccr_props
(
    // clock and reset
    input wire logic                         clock,
    input wire logic                         reset_n,
    // register port and events
    input wire cccr_pkg::cccr_request_type   request,
    input wire logic [7:0]                   readData,
    input wire logic [7:0]                   sectionParityError,
    input wire logic [7:0]                   cellParityError,
    input wire logic [63:0]                  channelAlarms,
    // core controls
    input wire cccr_pkg::cccr_cell_mode_type cellMode,
    input wire logic                         coreSoftReset,
    input wire logic                         serdesSoftReset,
    input wire logic                         txConfigDone,
    input wire logic                         alarmIndication
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire logic wrSel = request.writeStrobe && request.address == `CCCR_OFS_SELECT_MODE;
    wire logic wrTx  = request.writeStrobe && request.address == `CCCR_OFS_TX_STROBE
                       && request.writeData[7];
    wire logic wrRst = request.writeStrobe && request.address == `CCCR_OFS_RESET_CTRL
                       && request.writeData[7];

    property p_read_idle;
        !request.readStrobe |=> readData == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
    property p_pairs_ignored;
        cellMode.allLinks |-> cellMode.pairs == 4'h0;
    endproperty
    a_pairs_ignored: assert property (p_pairs_ignored) else $error("pairs with all links");
    property p_all_follow;
        wrSel && request.writeData[7] ##1 !wrSel |=> cellMode.allLinks;
    endproperty
    a_all_follow: assert property (p_all_follow) else $error("all links not set");
    property p_pairs_follow;
        wrSel && request.writeData[7:3] == 5'b01111 ##1 !wrSel |=> cellMode.pairs == 4'hf;
    endproperty
    a_pairs_follow: assert property (p_pairs_follow) else $error("pairs not set");
    property p_mode_hold;
        !wrSel [*2] |=> $stable(cellMode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("cell mode moved");
    property p_serdes;
        serdesSoftReset == 1'b0;
    endproperty
    a_serdes: assert property (p_serdes) else $error("serdes reset driven");
    property p_tx_pulse;
        txConfigDone |=> !txConfigDone;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx done too long");
    property p_tx_cause;
        txConfigDone |-> $past(wrTx, 2);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("tx done without write");
    property p_alarm;
        1'b1 |=> alarmIndication == |$past(channelAlarms);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm indication wrong");
    property p_soft_rise;
        wrRst && !coreSoftReset |-> ##[2:6] coreSoftReset;
    endproperty
    a_soft_rise: assert property (p_soft_rise) else $error("soft reset late");
endmodule : cccr_props

/* File: verif/cccr_host.sv */
// register bus host model
`timescale 1ns/1ps

module cccr_host
(
    // clock and read data
    input wire logic                  clock,
    input wire logic [7:0]            readData,
    // register port
    output cccr_pkg::cccr_request_type request
);
    initial request = '0;

    task automatic write(input logic [19:0] addr, input logic [7:0] data);
        @(posedge clock);
        request <= '{addr, data, 1'b1, 1'b0};
        @(posedge clock);
        request <= '{~addr, ~data, 1'b0, 1'b0};
    endtask : write

    task automatic read(input logic [19:0] addr, output logic [7:0] data);
        @(posedge clock);
        request <= '{addr, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        request <= '{~addr, 8'hff, 1'b0, 1'b0};
        #1;
        data = readData;
    endtask : read
endmodule : cccr_host

/* File: verif/cccr_top_test.sv */
// self-checking bench for the core common control register bank
`timescale 1ns/1ps
`include "cccr_params.svh"

module cccr_top_test;
    logic                         clock, reset_n, coreSoftReset, serdesSoftReset;
    logic                         txConfigDone, alarmIndication;
    cccr_pkg::cccr_request_type   request;
    logic [7:0]                   readData, sectionParityError, cellParityError, v, d;
    logic [63:0]                  channelAlarms;
    cccr_pkg::cccr_cell_mode_type cellMode;
    int nErrors, nCompared, secCnt, cellCnt, secSnap, cellSnap, sel, errOn, txPulses, lat0, n;
    int seed = 32'hf39a;

    cccr_host u_cccr_host (.clock(clock), .readData(readData), .request(request));
    cccr_top u_cccr_top (.clock(clock), .reset_n(reset_n), .request(request),
        .readData(readData), .sectionParityError(sectionParityError),
        .cellParityError(cellParityError), .channelAlarms(channelAlarms), .cellMode(cellMode),
        .coreSoftReset(coreSoftReset), .serdesSoftReset(serdesSoftReset),
        .txConfigDone(txConfigDone), .alarmIndication(alarmIndication));

    function automatic int tally(int c, logic hit, logic clr);
        if (clr)
            return int'(hit);
        return (hit && c < 255) ? c + 1 : c;
    endfunction : tally

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic expect_reg(input logic [19:0] a, input logic [7:0] exp);
        u_cccr_host.read(a, d);
        if (a == `CCCR_OFS_SECTION_TALLY)
            exp = 8'(secSnap);
        if (a == `CCCR_OFS_CELL_TALLY)
            exp = 8'(cellSnap);
        check(d, exp);
    endtask : expect_reg

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // tally model and error stimulus
    always @(posedge clock)
    begin
        secSnap = secCnt;
        cellSnap = cellCnt;
        secCnt = !reset_n ? 0 : tally(secCnt, sectionParityError[sel],
            request.readStrobe && request.address == `CCCR_OFS_SECTION_TALLY);
        cellCnt = !reset_n ? 0 : tally(cellCnt, cellParityError[sel],
            request.readStrobe && request.address == `CCCR_OFS_CELL_TALLY);
        if (txConfigDone === 1'b1)
            txPulses++;
        sectionParityError <= errOn == 2 ? 8'hff : errOn == 1 ? 8'($random(seed)) : 8'h00;
        cellParityError <= errOn == 2 ? 8'hff : errOn == 1 ? 8'($random(seed)) : 8'h00;
    end

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        #200_000;
        nErrors++;
        print_verdict();
    end

    initial
    begin
        reset_n = 1'b0;
        sectionParityError = 8'h00;
        cellParityError = 8'h00;
        channelAlarms = 64'h0;
        errOn = 0;
        sel = 0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        u_cccr_host.write(`CCCR_OFS_ALARM_SUMMARY, 8'hff);
        u_cccr_host.write(20'h3_0a0b, 8'hff);
        for (int a = 5; a < 12; a++)
            expect_reg(20'h3_0a00 + 20'(a), 8'h00);
        $display("reset values done");
        for (int i = 0; i < 8; i++)
        begin
            v = i == 0 ? 8'h78 : i == 1 ? 8'hf8 : 8'($random(seed));
            u_cccr_host.write(`CCCR_OFS_SELECT_MODE, v);
            expect_reg(`CCCR_OFS_SELECT_MODE, v);
            check(8'(cellMode.allLinks), 8'(v[7]));
            check(8'(cellMode.pairs), v[7] ? 8'h00 : 8'(v[6:3]));
        end
        $display("cell mode done");
        for (int ch = 0; ch < 8; ch++)
        begin
            errOn = 0;
            u_cccr_host.write(`CCCR_OFS_SELECT_MODE, 8'(ch));
            sel = ch;
            errOn = 1;
            repeat (20) @(posedge clock);
            expect_reg(`CCCR_OFS_SECTION_TALLY, 8'h00);
            expect_reg(`CCCR_OFS_CELL_TALLY, 8'h00);
        end
        errOn = 2;
        repeat (300) @(posedge clock);
        expect_reg(`CCCR_OFS_SECTION_TALLY, 8'h00);
        expect_reg(`CCCR_OFS_CELL_TALLY, 8'h00);
        errOn = 0;
        $display("tallies done");
        for (int p = 0; p < 4; p++)
        begin
            u_cccr_host.write(`CCCR_OFS_RESET_CTRL, 8'(p << 5) | 8'h9f);
            n = 0;
            while (coreSoftReset !== 1'b1 && n < 20)
            begin
                @(posedge clock);
                n++;
            end
            check(8'(coreSoftReset), 8'h01);
            lat0 = p == 0 ? n : lat0;
            check(8'(n - lat0), 8'(p));
            expect_reg(`CCCR_OFS_RESET_CTRL, 8'(p << 5) | 8'h80);
            expect_reg(`CCCR_OFS_SELECT_MODE, 8'h07);
            expect_reg(`CCCR_OFS_CELL_TALLY, 8'h00);
            check(8'(serdesSoftReset), 8'h00);
            u_cccr_host.write(`CCCR_OFS_RESET_CTRL, 8'h00);
            repeat (8) @(posedge clock);
            check(8'(coreSoftReset), 8'h00);
        end
        $display("soft reset done");
        txPulses = 0;
        u_cccr_host.write(`CCCR_OFS_TX_STROBE, 8'h00);
        u_cccr_host.write(`CCCR_OFS_TX_STROBE, 8'hff);
        expect_reg(`CCCR_OFS_TX_STROBE, 8'h80);
        u_cccr_host.write(`CCCR_OFS_TX_STROBE, 8'h80);
        repeat (4) @(posedge clock);
        check(8'(txPulses), 8'h01);
        $display("transmit done strobe done");
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clock);
            channelAlarms <= 64'(8'($random(seed)) | 8'h01) << (c * 8);
            repeat (3) @(posedge clock);
            expect_reg(`CCCR_OFS_ALARM_SUMMARY, 8'h80 >> c);
            check(8'(alarmIndication), 8'h01);
        end
        @(posedge clock);
        channelAlarms <= 64'h0;
        repeat (3) @(posedge clock);
        check(8'(alarmIndication), 8'h00);
        $display("alarms done");
        print_verdict();
    end
endmodule : cccr_top_test

bind cccr_top cccr_props u_cccr_props (.clock(clock), .reset_n(reset_n), .request(request),
    .readData(readData), .sectionParityError(sectionParityError),
    .cellParityError(cellParityError), .channelAlarms(channelAlarms), .cellMode(cellMode),
    .coreSoftReset(coreSoftReset), .serdesSoftReset(serdesSoftReset),
    .txConfigDone(txConfigDone), .alarmIndication(alarmIndication));
